// ===== vtm_pkg.sv
package vtm_pkg;
  // ----------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam logic [ADR_W-1:0] ADR_TC_STATUS = 4'h0;
  localparam logic [ADR_W-1:0] ADR_TRACE_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] ADR_IRQ_STATUS = 4'h8;
  localparam logic [ADR_W-1:0] ADR_TRACE_CTRL = 4'hC;
  localparam logic [REG_W-1:0] RST_STATUS = 8'h00;
  localparam logic [REG_W-1:0] RST_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TC_RDI_POS = 6;
  localparam int TC_ODI_POS = 5;
  localparam int TC_API_MM_POS = 4;
  localparam int TC_API_UNST_POS = 3;
  localparam int TC_LOMF_POS = 2;
  localparam int TC_UNEQ_POS = 1;
  localparam int TC_AIS_POS = 0;
  localparam int TR_TIM_POS = 2;
  localparam int TR_UNST_POS = 1;
  localparam int IRQ_APS_POS = 1;
  localparam int IRQ_OVF_POS = 0;
  localparam int CTRL_THR_POS = 3;

  // ----------------------------------------------------------------
  // Tandem multiframe and persistence figures
  // ----------------------------------------------------------------
  localparam logic [6:0] RDI_FRAME = 7'h49;
  localparam logic [6:0] ODI_FRAME = 7'h4A;
  localparam int RDI_BIT = 0;
  localparam int ODI_BIT = 1;
  localparam logic [2:0] PERSIST_N = 3'h5;
  localparam logic [2:0] ACC_LOW = 3'h3;
  localparam logic [2:0] ACC_HIGH = 3'h5;
  localparam logic [3:0] UNST_LIMIT = 4'h8;
  localparam int TIM_WIN = 5;
  localparam int TIM_CLR_MIN = 4;
  localparam logic [7:0] N2_AIS_PATTERN = 8'hFF;
  localparam logic [2:0] APS_PERSIST = 3'h3;
  localparam int APS_W = 4;
endpackage : vtm_pkg

// ===== vtm_trace_monitor.sv
`timescale 1ns/1ns
module vtm_trace_monitor (
  // System
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [vtm_pkg::ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [vtm_pkg::DAT_W-1:0] wbDatW,
  output logic [vtm_pkg::DAT_W-1:0] wbDatR,
  output logic wbAck,
  // Tandem multiframe
  input wire logic tcFrameStb,
  input wire logic [6:0] tcFrameIdx,
  input wire logic [7:0] tcFrameData,
  input wire logic n2Stb,
  input wire logic [7:0] n2Byte,
  input wire logic tandemMultiframeLoss,
  input wire logic tandemUnequipped,
  // Messages: index 0 access identifier, 1 path trace
  input wire logic [1:0] msgStb,
  input wire logic [1:0] msgEqPrev,
  input wire logic [1:0] msgEqExp,
  // APS and FIFO events
  input wire logic apsStb,
  input wire logic [vtm_pkg::APS_W-1:0] apsVal,
  input wire logic txFifoOvf,
  input wire logic rxFifoOvf
);
  import vtm_pkg::*;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [DAT_W-1:0] rdat_ff;
  logic [REG_W-1:0] ctrl_ff;
  logic [1:0] irq_ff;
  logic [REG_W-1:0] tcReg;
  logic [REG_W-1:0] trReg;
  logic [REG_W-1:0] rdMux;
  logic reqNew;
  logic irqRead;
  logic [2:0] accN;

  assign reqNew = wbCyc && wbStb && !ack_ff;
  // Clearing at the launch edge means the data latched equals what is cleared
  assign irqRead = reqNew && !wbWe && (wbAdr == ADR_IRQ_STATUS);
  assign accN = ctrl_ff[CTRL_THR_POS] ? ACC_HIGH : ACC_LOW;
  assign wbAck = ack_ff;
  assign wbDatR = rdat_ff;

  always_comb begin
    if (wbAdr == ADR_TC_STATUS) begin
      rdMux = tcReg;
    end else if (wbAdr == ADR_TRACE_STATUS) begin
      rdMux = trReg;
    end else if (wbAdr == ADR_IRQ_STATUS) begin
      rdMux = {6'h00, irq_ff};
    end else if (wbAdr == ADR_TRACE_CTRL) begin
      rdMux = ctrl_ff;
    end else begin
      rdMux = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff <= reqNew;
      if (reqNew && !wbWe) begin
        rdat_ff <= {24'h00_0000, rdMux};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= RST_CTRL;
    end else if (ce) begin
      if (reqNew && wbWe && wbSel[0] && wbAdr == ADR_TRACE_CTRL) begin
        ctrl_ff <= {4'h0, wbDatW[CTRL_THR_POS], 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Remote and outgoing defect persistence
  // ----------------------------------------------------------------
  logic [1:0] tcDef;

  for (genvar g = 0; g < 2; g++) begin : gPer
    localparam logic [6:0] IDX = (g == 0) ? RDI_FRAME : ODI_FRAME;
    localparam int BP = (g == 0) ? RDI_BIT : ODI_BIT;
    logic hit;
    logic bitNow;
    logic last_ff;
    logic def_ff;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    assign hit = tcFrameStb && (tcFrameIdx == IDX);
    assign bitNow = tcFrameData[BP];
    always_comb begin
      if (bitNow != last_ff || cnt_ff == 3'h0) begin
        nxt_cnt = 3'h1;
      end else if (cnt_ff == PERSIST_N) begin
        nxt_cnt = PERSIST_N;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        last_ff <= 1'b0;
        cnt_ff <= 3'h0;
        def_ff <= 1'b0;
      end else if (ce && hit) begin
        last_ff <= bitNow;
        cnt_ff <= nxt_cnt;
        if (nxt_cnt == PERSIST_N) begin
          def_ff <= bitNow;
        end
      end
    end
    assign tcDef[g] = def_ff;
  end

  // ----------------------------------------------------------------
  // Message acceptance and instability, both message streams
  // ----------------------------------------------------------------
  logic [1:0] msgAcc;
  logic [1:0] msgStable;
  logic [1:0] msgUnst;

  for (genvar i = 0; i < 2; i++) begin : gMsg
    logic [2:0] same_ff;
    logic [2:0] nxt_same;
    logic [3:0] unst_ff;
    logic unstDef_ff;
    always_comb begin
      if (!msgEqPrev[i]) begin
        nxt_same = 3'h1;
      end else if (same_ff == ACC_HIGH) begin
        nxt_same = ACC_HIGH;
      end else begin
        nxt_same = same_ff + 3'h1;
      end
    end
    assign msgAcc[i] = msgStb[i] && (nxt_same == accN);
    assign msgStable[i] = msgStb[i] && (nxt_same >= accN);
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        same_ff <= 3'h0;
        unst_ff <= 4'h0;
        unstDef_ff <= 1'b0;
      end else if (ce && msgStb[i]) begin
        same_ff <= nxt_same;
        if (msgStable[i]) begin
          unst_ff <= 4'h0;
          unstDef_ff <= 1'b0;
        end else if (!msgEqPrev[i] && unst_ff != UNST_LIMIT) begin
          unst_ff <= unst_ff + 4'h1;
          if (unst_ff + 4'h1 == UNST_LIMIT) begin
            unstDef_ff <= 1'b1;
          end
        end
      end
    end
    assign msgUnst[i] = unstDef_ff;
  end

  // ----------------------------------------------------------------
  // Identifier mismatch
  // ----------------------------------------------------------------
  logic [2:0] expRun_ff;
  logic [2:0] nxt_expRun;
  logic apiMm_ff;

  always_comb begin
    if (!msgEqExp[0]) begin
      nxt_expRun = 3'h0;
    end else if (expRun_ff == ACC_HIGH) begin
      nxt_expRun = ACC_HIGH;
    end else begin
      nxt_expRun = expRun_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      expRun_ff <= 3'h0;
      apiMm_ff <= 1'b0;
    end else if (ce && msgStb[0]) begin
      expRun_ff <= nxt_expRun;
      if (msgAcc[0] && !msgEqExp[0]) begin
        apiMm_ff <= 1'b1;
      end else if (nxt_expRun >= accN) begin
        apiMm_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trace mismatch over a five message window
  // ----------------------------------------------------------------
  logic [TIM_WIN-1:0] timWin_ff;
  logic [TIM_WIN-1:0] nxt_timWin;
  logic tim_ff;

  assign nxt_timWin = {timWin_ff[TIM_WIN-2:0], msgEqExp[1]};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timWin_ff <= '0;
      tim_ff <= 1'b0;
    end else if (ce && msgStb[1]) begin
      timWin_ff <= nxt_timWin;
      if (nxt_timWin == '0) begin
        tim_ff <= 1'b1;
      end else if ($countones(nxt_timWin) >= TIM_CLR_MIN) begin
        tim_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Live tandem status
  // ----------------------------------------------------------------
  logic ais_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ais_ff <= 1'b0;
    end else if (ce && n2Stb) begin
      ais_ff <= (n2Byte == N2_AIS_PATTERN);
    end
  end

  always_comb begin
    tcReg = RST_STATUS;
    tcReg[TC_RDI_POS] = tcDef[0];
    tcReg[TC_ODI_POS] = tcDef[1];
    tcReg[TC_API_MM_POS] = apiMm_ff;
    tcReg[TC_API_UNST_POS] = msgUnst[0];
    tcReg[TC_LOMF_POS] = tandemMultiframeLoss;
    tcReg[TC_UNEQ_POS] = tandemUnequipped;
    tcReg[TC_AIS_POS] = ais_ff;
    trReg = RST_STATUS;
    trReg[TR_TIM_POS] = tim_ff;
    trReg[TR_UNST_POS] = msgUnst[1];
  end

  // ----------------------------------------------------------------
  // APS acceptance and reset-on-read events
  // ----------------------------------------------------------------
  logic [APS_W-1:0] apsLast_ff;
  logic [APS_W-1:0] apsAcc_ff;
  logic [2:0] apsRun_ff;
  logic [2:0] nxt_apsRun;
  logic apsEvt;
  logic [1:0] irqSet;

  always_comb begin
    if (apsVal != apsLast_ff || apsRun_ff == 3'h0) begin
      nxt_apsRun = 3'h1;
    end else if (apsRun_ff == APS_PERSIST) begin
      nxt_apsRun = APS_PERSIST;
    end else begin
      nxt_apsRun = apsRun_ff + 3'h1;
    end
  end

  assign apsEvt = apsStb && (nxt_apsRun == APS_PERSIST) && (apsVal != apsAcc_ff);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      apsLast_ff <= '0;
      apsAcc_ff <= '0;
      apsRun_ff <= 3'h0;
    end else if (ce && apsStb) begin
      apsLast_ff <= apsVal;
      apsRun_ff <= nxt_apsRun;
      if (apsEvt) begin
        apsAcc_ff <= apsVal;
      end
    end
  end

  always_comb begin
    irqSet = 2'h0;
    irqSet[IRQ_APS_POS] = apsEvt;
    irqSet[IRQ_OVF_POS] = txFifoOvf || rxFifoOvf;
  end

  // Set wins over the read clear so no event is lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 2'h0;
    end else if (ce) begin
      irq_ff <= (irqRead ? 2'h0 : irq_ff) | irqSet;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rdiHigh;
    ce && gPer[0].hit && tcFrameData[RDI_BIT];
  endsequence
  sequence s_rdiLow;
    ce && gPer[0].hit && !tcFrameData[RDI_BIT];
  endsequence

  property p_rdiSet;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(tcDef[0]) |-> $past(gPer[0].cnt_ff) == PERSIST_N - 3'h1 && $past(tcFrameData[RDI_BIT]);
  endproperty
  a_rdiSet: assert property (p_rdiSet) else $error("remote defect set early");

  property p_rdiClr;
    @(posedge clk_sys) disable iff (!resetn)
    gPer[0].def_ff && gPer[0].cnt_ff == PERSIST_N - 3'h1 && !gPer[0].last_ff ##0 s_rdiLow
      |=> !tcDef[0];
  endproperty
  a_rdiClr: assert property (p_rdiClr) else $error("remote defect not cleared");

  property p_odiHold;
    @(posedge clk_sys) disable iff (!resetn)
    $changed(tcDef[1]) |-> $past(gPer[1].hit) && $past(gPer[1].nxt_cnt) == PERSIST_N;
  endproperty
  a_odiHold: assert property (p_odiHold) else $error("outgoing defect moved off run");

  property p_runBreak;
    @(posedge clk_sys) disable iff (!resetn)
    s_rdiHigh ##0 !gPer[0].last_ff |=> gPer[0].cnt_ff == 3'h1;
  endproperty
  a_runBreak: assert property (p_runBreak) else $error("persistence run not restarted");

  property p_apiMm;
    @(posedge clk_sys) disable iff (!resetn)
    ce && msgAcc[0] && !msgEqExp[0] |=> apiMm_ff;
  endproperty
  a_apiMm: assert property (p_apiMm) else $error("identifier mismatch not declared");

  property p_unst;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(msgUnst[1]) |-> gMsg[1].unst_ff == UNST_LIMIT;
  endproperty
  a_unst: assert property (p_unst) else $error("trace unstable off count");

  property p_stableClr;
    @(posedge clk_sys) disable iff (!resetn)
    ce && msgStable[0] |=> !msgUnst[0] && gMsg[0].unst_ff == 4'h0;
  endproperty
  a_stableClr: assert property (p_stableClr) else $error("identifier unstable kept");

  property p_timSet;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(tim_ff) |-> timWin_ff == '0;
  endproperty
  a_timSet: assert property (p_timSet) else $error("trace mismatch set with a match");

  property p_evtSticky;
    @(posedge clk_sys) disable iff (!resetn)
    ce && irqSet != 2'h0 |=> (irq_ff & $past(irqSet)) == $past(irqSet) ##1
      ($past(irqRead && ce) || (irq_ff & $past(irqSet, 2)) == $past(irqSet, 2));
  endproperty
  a_evtSticky: assert property (p_evtSticky) else $error("event bit lost");

  property p_trReserved;
    @(posedge clk_sys) disable iff (!resetn)
    ack_ff && !wbWe && wbAdr == ADR_TRACE_STATUS |-> rdat_ff[7:3] == 5'h00 && !rdat_ff[0];
  endproperty
  a_trReserved: assert property (p_trReserved) else $error("reserved trace bits set");
endmodule : vtm_trace_monitor

// ===== vtm_line_model.sv
`timescale 1ns/1ns
module vtm_line_model (
  // Clock
  input wire logic clk_sys,
  // Tandem multiframe and N2
  output logic tcFrameStb,
  output logic [6:0] tcFrameIdx,
  output logic [7:0] tcFrameData,
  output logic n2Stb,
  output logic [7:0] n2Byte,
  // Messages and APS
  output logic [1:0] msgStb,
  output logic [1:0] msgEqPrev,
  output logic [1:0] msgEqExp,
  output logic apsStb,
  output logic [3:0] apsVal
);
  initial begin
    tcFrameStb = 1'b0;
    tcFrameIdx = 7'h00;
    tcFrameData = 8'h00;
    n2Stb = 1'b0;
    n2Byte = 8'h00;
    msgStb = 2'h0;
    msgEqPrev = 2'h0;
    msgEqExp = 2'h0;
    apsStb = 1'b0;
    apsVal = 4'h0;
  end

  // ----------------------------------------------------------------
  // Strobes; released data shows inverse so stale values never match
  // ----------------------------------------------------------------
  task automatic sendFrame(input logic [6:0] idx, input logic [7:0] dat);
    @(posedge clk_sys);
    tcFrameStb <= 1'b1;
    tcFrameIdx <= idx;
    tcFrameData <= dat;
    @(posedge clk_sys);
    tcFrameStb <= 1'b0;
    tcFrameData <= ~dat;
  endtask : sendFrame

  task automatic sendN2(input logic [7:0] b);
    @(posedge clk_sys);
    n2Stb <= 1'b1;
    n2Byte <= b;
    @(posedge clk_sys);
    n2Stb <= 1'b0;
    n2Byte <= ~b;
  endtask : sendN2

  task automatic sendMsg(input int ch, input logic prev, input logic exp);
    @(posedge clk_sys);
    msgStb <= 2'h1 << ch;
    msgEqPrev <= {2{prev}};
    msgEqExp <= {2{exp}};
    @(posedge clk_sys);
    msgStb <= 2'h0;
    msgEqPrev <= {2{~prev}};
    msgEqExp <= {2{~exp}};
  endtask : sendMsg

  task automatic sendAps(input logic [3:0] v);
    @(posedge clk_sys);
    apsStb <= 1'b1;
    apsVal <= v;
    @(posedge clk_sys);
    apsStb <= 1'b0;
    apsVal <= ~v;
  endtask : sendAps
endmodule : vtm_line_model

// ===== test_vt_tandem_trace_defect_monitor.sv
`timescale 1ns/1ns
module test_vt_tandem_trace_defect_monitor;
  import vtm_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [ADR_W-1:0] wbAdr = '0;
  logic [3:0] wbSel = 4'h0;
  logic [DAT_W-1:0] wbDatW = '0;
  logic [DAT_W-1:0] wbDatR;
  logic wbAck;
  logic tcFrameStb, n2Stb, apsStb;
  logic [6:0] tcFrameIdx;
  logic [7:0] tcFrameData, n2Byte;
  logic [1:0] msgStb, msgEqPrev, msgEqExp;
  logic [3:0] apsVal;
  logic tandemMultiframeLoss = 1'b0;
  logic tandemUnequipped = 1'b0;
  logic txFifoOvf = 1'b0;
  logic rxFifoOvf = 1'b0;
  int numErrors = 0;
  int compares = 0;

  always #4 clk_sys = ~clk_sys;

  vtm_line_model vtm_line_model_inst (.clk_sys(clk_sys), .tcFrameStb(tcFrameStb),
    .tcFrameIdx(tcFrameIdx), .tcFrameData(tcFrameData), .n2Stb(n2Stb), .n2Byte(n2Byte),
    .msgStb(msgStb), .msgEqPrev(msgEqPrev), .msgEqExp(msgEqExp), .apsStb(apsStb),
    .apsVal(apsVal));

  vtm_trace_monitor vtm_trace_monitor_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .tcFrameStb(tcFrameStb),
    .tcFrameIdx(tcFrameIdx), .tcFrameData(tcFrameData), .n2Stb(n2Stb), .n2Byte(n2Byte),
    .tandemMultiframeLoss(tandemMultiframeLoss), .tandemUnequipped(tandemUnequipped),
    .msgStb(msgStb), .msgEqPrev(msgEqPrev), .msgEqExp(msgEqExp), .apsStb(apsStb),
    .apsVal(apsVal), .txFifoOvf(txFifoOvf), .rxFifoOvf(rxFifoOvf));

  // ----------------------------------------------------------------
  // Reporting and bus access
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits for ack without assuming a latency; bounded so a hang ends the run
  task automatic wbXfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatW <= wd;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk_sys);
      if (wbAck === 1'b1) break;
      if (i == 20) begin
        numErrors++;
        conclude();
      end
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer

  task automatic rdReg(input logic [ADR_W-1:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    wbXfer(1'b0, adr, 32'h0, rd);
    check(what, rd, exp);
  endtask : rdReg

  task automatic rdBit(input logic [ADR_W-1:0] adr, input int pos, input logic exp,
                       input string what);
    logic [31:0] rd;
    wbXfer(1'b0, adr, 32'h0, rd);
    check(what, {31'h0, rd[pos]}, {31'h0, exp});
  endtask : rdBit

  task automatic msgs(input int ch, input int n, input logic prev, input logic exp);
    repeat (n) vtm_line_model_inst.sendMsg(ch, prev, exp);
  endtask : msgs

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    rdReg(ADR_TC_STATUS, {24'h0, RST_STATUS}, "tcStatus");
    rdReg(ADR_TRACE_STATUS, {24'h0, RST_STATUS}, "traceStatus");
    rdReg(ADR_IRQ_STATUS, {24'h0, RST_STATUS}, "irqStatus");
    rdReg(ADR_TRACE_CTRL, {24'h0, RST_CTRL}, "traceCtrl");
    $display("reset test done");
  endtask : testReset

  // Broken run first, so a counter that never restarts sets too early
  task automatic testPersist(input logic [6:0] idx, input int bitNo, input int pos);
    logic [7:0] one;
    one = 8'h01 << bitNo;
    repeat (5) vtm_line_model_inst.sendFrame(idx - 7'h02, one);
    rdBit(ADR_TC_STATUS, pos, 1'b0, "otherFrame");
    repeat (4) vtm_line_model_inst.sendFrame(idx, one);
    vtm_line_model_inst.sendFrame(idx, ~one);
    repeat (4) vtm_line_model_inst.sendFrame(idx, one);
    rdBit(ADR_TC_STATUS, pos, 1'b0, "brokenRun");
    vtm_line_model_inst.sendFrame(idx, one);
    rdBit(ADR_TC_STATUS, pos, 1'b1, "defectSet");
    repeat (4) vtm_line_model_inst.sendFrame(idx, ~one);
    rdBit(ADR_TC_STATUS, pos, 1'b1, "defectHeld");
    vtm_line_model_inst.sendFrame(idx, ~one);
    rdBit(ADR_TC_STATUS, pos, 1'b0, "defectClear");
    $display("persistence test done");
  endtask : testPersist

  task automatic testLive();
    @(posedge clk_sys);
    tandemMultiframeLoss <= 1'b1;
    vtm_line_model_inst.sendN2(N2_AIS_PATTERN);
    rdReg(ADR_TC_STATUS, 32'h1 << TC_LOMF_POS | 32'h1 << TC_AIS_POS, "lossAlarm");
    @(posedge clk_sys);
    tandemMultiframeLoss <= 1'b0;
    tandemUnequipped <= 1'b1;
    vtm_line_model_inst.sendN2(8'hFE);
    rdReg(ADR_TC_STATUS, 32'h1 << TC_UNEQ_POS, "unequipped");
    @(posedge clk_sys);
    tandemUnequipped <= 1'b0;
    $display("live status test done");
  endtask : testLive

  task automatic testIdMismatch();
    msgs(0, 1, 1'b0, 1'b0);
    msgs(0, 1, 1'b1, 1'b0);
    rdBit(ADR_TC_STATUS, TC_API_MM_POS, 1'b0, "idNotAccepted");
    msgs(0, 1, 1'b1, 1'b0);
    rdBit(ADR_TC_STATUS, TC_API_MM_POS, 1'b1, "idMismatch");
    msgs(0, 1, 1'b0, 1'b1);
    msgs(0, 1, 1'b1, 1'b1);
    rdBit(ADR_TC_STATUS, TC_API_MM_POS, 1'b1, "idHeld");
    msgs(0, 1, 1'b1, 1'b1);
    rdBit(ADR_TC_STATUS, TC_API_MM_POS, 1'b0, "idClear");
    $display("identifier mismatch test done");
  endtask : testIdMismatch

  // Threshold 5 used for clearing, so a design stuck at 3 clears early
  task automatic testUnstable(input int ch, input logic [ADR_W-1:0] adr, input int pos);
    logic [31:0] rd;
    msgs(ch, 7, 1'b0, 1'b1);
    rdBit(adr, pos, 1'b0, "unstableBelow");
    msgs(ch, 1, 1'b0, 1'b1);
    rdBit(adr, pos, 1'b1, "unstableSet");
    wbXfer(1'b1, ADR_TRACE_CTRL, 32'h1 << CTRL_THR_POS, rd);
    rdReg(ADR_TRACE_CTRL, 32'h1 << CTRL_THR_POS, "thresholdBack");
    msgs(ch, 3, 1'b1, 1'b1);
    rdBit(adr, pos, 1'b1, "unstableHeld");
    msgs(ch, 1, 1'b1, 1'b1);
    rdBit(adr, pos, 1'b0, "unstableClear");
    msgs(ch, 7, 1'b0, 1'b1);
    rdBit(adr, pos, 1'b0, "counterZeroed");
    wbXfer(1'b1, ADR_TRACE_CTRL, 32'h0, rd);
    $display("unstable test done");
  endtask : testUnstable

  task automatic testTim();
    msgs(1, 5, 1'b1, 1'b1);
    rdBit(ADR_TRACE_STATUS, TR_TIM_POS, 1'b0, "timClean");
    msgs(1, 4, 1'b1, 1'b0);
    rdBit(ADR_TRACE_STATUS, TR_TIM_POS, 1'b0, "timOneMatch");
    msgs(1, 1, 1'b1, 1'b0);
    rdReg(ADR_TRACE_STATUS, 32'h1 << TR_TIM_POS, "timSet");
    msgs(1, 3, 1'b1, 1'b1);
    rdBit(ADR_TRACE_STATUS, TR_TIM_POS, 1'b1, "timSixty");
    msgs(1, 1, 1'b1, 1'b1);
    rdBit(ADR_TRACE_STATUS, TR_TIM_POS, 1'b0, "timEighty");
    $display("trace mismatch test done");
  endtask : testTim

  task automatic testIrq();
    repeat (2) vtm_line_model_inst.sendAps(4'h5);
    rdReg(ADR_IRQ_STATUS, 32'h0, "apsEarly");
    vtm_line_model_inst.sendAps(4'h5);
    rdReg(ADR_IRQ_STATUS, 32'h1 << IRQ_APS_POS, "apsAccept");
    rdReg(ADR_IRQ_STATUS, 32'h0, "apsCleared");
    repeat (3) vtm_line_model_inst.sendAps(4'h5);
    rdReg(ADR_IRQ_STATUS, 32'h0, "apsSame");
    @(posedge clk_sys);
    txFifoOvf <= 1'b1;
    @(posedge clk_sys);
    txFifoOvf <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdReg(ADR_IRQ_STATUS, 32'h1 << IRQ_OVF_POS, "txOverflow");
    rdReg(ADR_IRQ_STATUS, 32'h0, "ovfCleared");
    @(posedge clk_sys);
    rxFifoOvf <= 1'b1;
    @(posedge clk_sys);
    rxFifoOvf <= 1'b0;
    rdReg(ADR_IRQ_STATUS, 32'h1 << IRQ_OVF_POS, "rxOverflow");
    // Event sampled at the very edge that launches the read must survive
    fork
      rdReg(ADR_IRQ_STATUS, 32'h0, "readAtEvent");
      begin
        @(posedge clk_sys);
        txFifoOvf <= 1'b1;
        @(posedge clk_sys);
        txFifoOvf <= 1'b0;
      end
    join
    rdReg(ADR_IRQ_STATUS, 32'h1 << IRQ_OVF_POS, "setWins");
    $display("interrupt test done");
  endtask : testIrq

  // Frozen clock enable must swallow a full APS acceptance run
  task automatic testCe();
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (3) vtm_line_model_inst.sendAps(4'hA);
    @(posedge clk_sys);
    ce <= 1'b1;
    rdReg(ADR_IRQ_STATUS, 32'h0, "frozenAps");
    @(posedge clk_sys);
    check("ackDrop", {31'h0, wbAck}, 32'h0);
    repeat (3) vtm_line_model_inst.sendAps(4'hA);
    rdReg(ADR_IRQ_STATUS, 32'h1 << IRQ_APS_POS, "apsNewValue");
    $display("clock enable test done");
  endtask : testCe

  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    testReset();
    testPersist(RDI_FRAME, RDI_BIT, TC_RDI_POS);
    testPersist(ODI_FRAME, ODI_BIT, TC_ODI_POS);
    testLive();
    testIdMismatch();
    testUnstable(0, ADR_TC_STATUS, TC_API_UNST_POS);
    testUnstable(1, ADR_TRACE_STATUS, TR_UNST_POS);
    testTim();
    testIrq();
    testCe();
    conclude();
  end
endmodule : test_vt_tandem_trace_defect_monitor
